/* File: cfs_top.sv */
// top: cpu frequency selection, recovery lock and register port
//
// What this block does
// RL1: on watchdog time-out the clock moves to a recovery setting, taken from the straps when the source bit is 0 or from the recovery n and m values when it is 1.
// RL2: except in strap recovery, the strap override bit picks the output ratio from the latched straps when clear or from the software select field when set.
// RL3: a write to the recovery n or recovery m value retunes the output.
// RL4: the host is advised to write recovery n and m together in one word or block transaction.
// RL5: with programmable frequency enabled the cpu frequency comes from programmed n and m.
// RL6: a new programmed frequency loads only on a write of the programmed m value, never on n alone.
// RL7: the n and m settings cover cpu frequencies from 50 MHz to 248 MHz.
// RL8: the enable bit is bit 7 of the programmed m byte, resets to 0, and the low seven bits hold m.
// RL9: the low two bits of the first reserved byte reset to one and the host must write them as one.
// RL10: a time-out pulses system reset, loads recovery and locks out frequency writes until watchdog enable is cleared.
// RL11: with programmable frequency off the frequency comes from the straps or the select field per the override bit.
// RL12: every frequency control byte reads back as stored, enable and source bits included.
`timescale 1ns/1ns
module cfs_top
	import cfs_pkg::*;
#(
	parameter int N_W = CFS_N_W,
	parameter int M_W = CFS_M_W
) (
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic [7:0]          reg_wdata_i,
	output logic      [7:0]          reg_rdata_o,
	output logic                     reg_rvalid_o,
	input  wire logic                watchdog_timeout_i,
	input  wire logic                watchdog_enable_i,
	input  wire logic                strap_override_i,
	input  wire logic [CFS_FS_W-1:0] strap_freq_inputs_i,
	input  wire logic [CFS_FS_W-1:0] sw_freq_select_i,
	output logic      [N_W-1:0]      cpu_n_o,
	output logic      [M_W-1:0]      cpu_m_o,
	output logic      [CFS_FS_W-1:0] ratio_select_o,
	output logic                     use_nm_o,
	output logic                     retune_o,
	output logic                     sys_reset_o,
	output logic                     recovery_locked_o
);
	cfs_wr_if wr ();

	// frequency writes are dropped while locked so a hung system stays at the safe clock
	cfs_state_t state;
	cfs_state_t next_state;
	wire        locked    = (state == CFS_ST_LOCKED);
	wire        freq_addr = (reg_addr_i == CFS_OFF_RECOV_N) || (reg_addr_i == CFS_OFF_RECOV_M)
		|| (reg_addr_i == CFS_OFF_PROG_N) || (reg_addr_i == CFS_OFF_PROG_M);
	wire        wr_ok     = reg_wr_i && !(locked && freq_addr); // see RL10

	assign wr.wr_en   = wr_ok;
	assign wr.wr_addr = reg_addr_i;
	assign wr.wr_data = reg_wdata_i;

	cfs_regfile u_regs (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.wr        (wr)
	);

	// straps are pins: two flops before use
	logic [CFS_FS_W-1:0] strap_s1;
	logic [CFS_FS_W-1:0] strap_s2;
	logic [1:0]          ovr_s;
	logic [1:0]          to_s;
	logic [1:0]          en_s;
	logic                to_d;
	logic [CFS_FS_W-1:0] strap_latched;
	logic                strap_caught;
	logic [1:0]          strap_fill;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_s1 <= '0;
			strap_s2 <= '0;
			ovr_s    <= 2'h0;
			to_s     <= 2'h0;
			en_s     <= 2'h0;
			to_d     <= 1'b0;
			strap_fill <= 2'h0;
		end else begin
			strap_s1 <= strap_freq_inputs_i;
			strap_s2 <= strap_s1;
			ovr_s    <= {ovr_s[0], strap_override_i};
			to_s     <= {to_s[0], watchdog_timeout_i};
			en_s     <= {en_s[0], watchdog_enable_i};
			to_d     <= to_s[1];
			strap_fill <= {strap_fill[0], 1'b1};
		end
	end

	// straps latch once, only after the synchroniser has filled, so the reset zeros never latch
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_latched <= '0;
			strap_caught  <= 1'b0;
		end else if (!strap_caught && strap_fill[1]) begin
			strap_latched <= strap_s2;
			strap_caught  <= 1'b1;
		end
	end

	wire timeout_rise = to_s[1] && !to_d;

	always_comb begin
		next_state = state;
		case (state)
			CFS_ST_NORMAL: if (timeout_rise) next_state = CFS_ST_LOCKED; // see RL10
			CFS_ST_LOCKED: if (!en_s[1]) next_state = CFS_ST_NORMAL; // see RL10
			default:       next_state = CFS_ST_NORMAL;
		endcase
	end

	// field views of the stored bytes
	wire              src_nm   = wr.recov_m[CFS_BIT_SRC_SEL];
	wire              prog_en  = wr.prog_m[CFS_BIT_PROG_EN]; // see RL8
	wire [N_W-1:0]    rn       = wr.recov_n[N_W-1:0];
	wire [M_W-1:0]    rm       = wr.recov_m[M_W-1:0];
	wire [N_W-1:0]    pn       = wr.prog_n[N_W-1:0]; // see RL7
	wire [M_W-1:0]    pm       = wr.prog_m[M_W-1:0]; // see RL8

	// n and m are passed to the pll untouched; 50 to 248 MHz is reached by the n/m span
	wire [CFS_FS_W-1:0] ratio_sel = ovr_s[1] ? sw_freq_select_i : strap_latched; // see RL2, RL11

	wire hit_rec  = wr_ok && ((reg_addr_i == CFS_OFF_RECOV_N) || (reg_addr_i == CFS_OFF_RECOV_M));
	wire hit_pm   = wr_ok && (reg_addr_i == CFS_OFF_PROG_M);
	wire enter    = (state == CFS_ST_NORMAL) && timeout_rise;
	// the written enable bit counts at once so mode, n/m and retune land in one cycle
	wire prog_en_next = hit_pm ? reg_wdata_i[CFS_BIT_PROG_EN] : prog_en; // see RL5

	cfs_src_t src;
	cfs_src_t next_src;
	always_comb begin
		next_src = src;
		if (enter)
			next_src = src_nm ? CFS_SRC_RECOV : CFS_SRC_STRAP; // see RL1
		else if (!locked)
			next_src = prog_en_next ? CFS_SRC_PROG : (ovr_s[1] ? CFS_SRC_SEL : CFS_SRC_STRAP);
	end

	// prog n/m are sampled only on an m write, so n alone never moves the clock
	logic [N_W-1:0] load_n;
	logic [M_W-1:0] load_m;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			load_n <= '0;
			load_m <= '0;
		end else if (hit_pm) begin
			load_n <= pn; // see RL6
			load_m <= reg_wdata_i[M_W-1:0]; // see RL5, RL6
		end
	end

	// any accepted recovery write retunes, even when the pll runs from another source
	wire next_retune = enter || hit_rec // see RL3
		|| (hit_pm && reg_wdata_i[CFS_BIT_PROG_EN]); // see RL6

	logic [N_W-1:0]      next_n;
	logic [M_W-1:0]      next_m;
	always_comb begin
		case (next_src)
			CFS_SRC_RECOV: begin
				next_n = rn; // see RL1, RL3
				next_m = rm;
			end
			CFS_SRC_PROG: begin
				next_n = hit_pm ? pn : load_n; // see RL5
				next_m = hit_pm ? reg_wdata_i[M_W-1:0] : load_m;
			end
			default: begin
				next_n = '0;
				next_m = '0;
			end
		endcase
	end

	wire [7:0] rd_mux =
		(reg_addr_i == CFS_OFF_RECOV_N)   ? wr.recov_n :
		(reg_addr_i == CFS_OFF_RECOV_M)   ? wr.recov_m :
		(reg_addr_i == CFS_OFF_PROG_N)    ? wr.prog_n :
		(reg_addr_i == CFS_OFF_PROG_M)    ? wr.prog_m :
		(reg_addr_i == CFS_OFF_RSVD_ONES) ? wr.rsvd_ones : 8'h00; // see RL12

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state             <= CFS_ST_NORMAL;
			src               <= CFS_SRC_STRAP;
			cpu_n_o           <= '0;
			cpu_m_o           <= '0;
			ratio_select_o    <= '0;
			use_nm_o          <= 1'b0;
			retune_o          <= 1'b0;
			sys_reset_o       <= 1'b0;
			recovery_locked_o <= 1'b0;
			reg_rdata_o       <= 8'h00;
			reg_rvalid_o      <= 1'b0;
		end else begin
			state             <= next_state;
			src               <= next_src;
			cpu_n_o           <= next_n;
			cpu_m_o           <= next_m;
			// recovery from straps ignores override and uses the latched code
			ratio_select_o    <= (next_src == CFS_SRC_STRAP) ? strap_latched : ratio_sel; // see RL1
			use_nm_o          <= (next_src == CFS_SRC_RECOV) || (next_src == CFS_SRC_PROG);
			retune_o          <= next_retune;
			sys_reset_o       <= enter; // see RL10
			recovery_locked_o <= (next_state == CFS_ST_LOCKED);
			reg_rdata_o       <= reg_rd_i ? rd_mux : reg_rdata_o;
			reg_rvalid_o      <= reg_rd_i;
		end
	end
endmodule

/* File: cfs_pkg.sv */
// package: register map, reset values and frequency codes for the cpu frequency select logic
package cfs_pkg;
	localparam logic [7:0] CFS_OFF_RECOV_N    = 8'h0B;
	localparam logic [7:0] CFS_OFF_RECOV_M    = 8'h0C;
	localparam logic [7:0] CFS_OFF_PROG_N     = 8'h0D;
	localparam logic [7:0] CFS_OFF_PROG_M     = 8'h0E;
	localparam logic [7:0] CFS_OFF_RSVD_ONES  = 8'h0F;
	localparam logic [7:0] CFS_OFF_RSVD_SPARE = 8'h10;
	localparam logic [7:0] CFS_RST_BYTE       = 8'h00;
	localparam logic [7:0] CFS_RST_RSVD_ONES  = 8'h03;
	localparam int         CFS_BIT_SRC_SEL    = 7;
	localparam int         CFS_BIT_PROG_EN    = 7;
	localparam int         CFS_FS_W           = 5;
	localparam int         CFS_N_W            = 8;
	localparam int         CFS_M_W            = 7;
	localparam int         CFS_FREQ_MIN_MHZ   = 50;
	localparam int         CFS_FREQ_MAX_MHZ   = 248;
	localparam int         CFS_CLK_MHZ        = 20;
	localparam int         CFS_RETUNE_PULSE   = 1;

	typedef enum logic [1:0] {
		CFS_SRC_STRAP = 2'b00,
		CFS_SRC_SEL   = 2'b01,
		CFS_SRC_PROG  = 2'b11,
		CFS_SRC_RECOV = 2'b10
	} cfs_src_t;

	typedef enum logic [1:0] {
		CFS_ST_NORMAL = 2'b00,
		CFS_ST_LOCKED = 2'b01
	} cfs_state_t;
endpackage

/* File: cfs_wr_if.sv */
// interface: register write strobe and data between top and register file
`timescale 1ns/1ns
interface cfs_wr_if;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] recov_n;
	logic [7:0] recov_m;
	logic [7:0] prog_n;
	logic [7:0] prog_m;
	logic [7:0] rsvd_ones;
	modport ctl (output wr_en, output wr_addr, output wr_data,
		input recov_n, input recov_m, input prog_n, input prog_m, input rsvd_ones);
	modport regs (input wr_en, input wr_addr, input wr_data,
		output recov_n, output recov_m, output prog_n, output prog_m, output rsvd_ones);
endinterface

/* File: cfs_regfile.sv */
// register file: the five frequency control bytes
`timescale 1ns/1ns
module cfs_regfile
	import cfs_pkg::*;
(
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	cfs_wr_if.regs    wr
);
	wire hit_rn = wr.wr_en && (wr.wr_addr == CFS_OFF_RECOV_N);
	wire hit_rm = wr.wr_en && (wr.wr_addr == CFS_OFF_RECOV_M);
	wire hit_pn = wr.wr_en && (wr.wr_addr == CFS_OFF_PROG_N);
	wire hit_pm = wr.wr_en && (wr.wr_addr == CFS_OFF_PROG_M);
	wire hit_ro = wr.wr_en && (wr.wr_addr == CFS_OFF_RSVD_ONES);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr.recov_n   <= CFS_RST_BYTE;
			wr.recov_m   <= CFS_RST_BYTE;
			wr.prog_n    <= CFS_RST_BYTE;
			wr.prog_m    <= CFS_RST_BYTE; // see RL8
			wr.rsvd_ones <= CFS_RST_RSVD_ONES; // see RL9
		end else begin
			if (hit_rn) wr.recov_n <= wr.wr_data;
			if (hit_rm) wr.recov_m <= wr.wr_data;
			if (hit_pn) wr.prog_n <= wr.wr_data;
			if (hit_pm) wr.prog_m <= wr.wr_data;
			if (hit_ro) wr.rsvd_ones <= wr.wr_data;
		end
	end
endmodule

/* File: cfs_top_assertions.sv */
// checker: concurrent assertions on the cpu frequency select top ports
`timescale 1ns/1ns
module cfs_top_assertions
	import cfs_pkg::*;
#(
	parameter int N_W = CFS_N_W,
	parameter int M_W = CFS_M_W
) (
	input wire logic                clk_sys_i,
	input wire logic                rstn_i,
	input wire logic                reg_wr_i,
	input wire logic                reg_rd_i,
	input wire logic [7:0]          reg_addr_i,
	input wire logic [7:0]          reg_wdata_i,
	input wire logic [7:0]          reg_rdata_o,
	input wire logic                reg_rvalid_o,
	input wire logic                watchdog_timeout_i,
	input wire logic                watchdog_enable_i,
	input wire logic                strap_override_i,
	input wire logic [CFS_FS_W-1:0] strap_freq_inputs_i,
	input wire logic [CFS_FS_W-1:0] sw_freq_select_i,
	input wire logic [N_W-1:0]      cpu_n_o,
	input wire logic [M_W-1:0]      cpu_m_o,
	input wire logic [CFS_FS_W-1:0] ratio_select_o,
	input wire logic                use_nm_o,
	input wire logic                retune_o,
	input wire logic                sys_reset_o,
	input wire logic                recovery_locked_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	wire m_wr = reg_wr_i && reg_addr_i == CFS_OFF_PROG_M;
	wire n_wr = reg_wr_i && reg_addr_i == CFS_OFF_PROG_N;
	wire r_wr = reg_wr_i && (reg_addr_i == CFS_OFF_RECOV_N || reg_addr_i == CFS_OFF_RECOV_M);
	sequence s_timeout;
		!recovery_locked_o && $rose(watchdog_timeout_i);
	endsequence
	sequence s_entry;
		sys_reset_o && retune_o && recovery_locked_o;
	endsequence
	a_rd_answered: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read strobe not answered");
	a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("read valid without read strobe");
	a_prog_m_load: assert property (m_wr && reg_wdata_i[7] && !recovery_locked_o
		|=> retune_o && use_nm_o && cpu_m_o == $past(reg_wdata_i[6:0]))
		else $error("programmed m write did not load");
	a_prog_n_quiet: assert property (n_wr && !recovery_locked_o |=> !retune_o)
		else $error("programmed n write retuned");
	a_timeout_lock: assert property (s_timeout |-> ##3 s_entry)
		else $error("time-out did not lock in three cycles");
	a_reset_pulse: assert property ($rose(recovery_locked_o) |-> s_entry ##1 !sys_reset_o)
		else $error("lock entry reset pulse wrong");
	a_locked_drop: assert property (recovery_locked_o && m_wr |=> !retune_o)
		else $error("frequency write taken while locked");
	a_unlock_time: assert property ((!watchdog_enable_i && !watchdog_timeout_i)[*5]
		|-> !recovery_locked_o)
		else $error("lock not released");
	a_override_sel: assert property ((strap_override_i && !recovery_locked_o
		&& $stable(sw_freq_select_i))[*5] |-> ratio_select_o == sw_freq_select_i)
		else $error("ratio not from select field");
	a_recov_retune: assert property (r_wr && !recovery_locked_o |=> retune_o)
		else $error("recovery value write did not retune");
endmodule
bind cfs_top cfs_top_assertions #(.N_W(N_W), .M_W(M_W)) cfs_top_assertions_i (.*);

/* File: cfs_host_model.sv */
// partner: host controller issuing byte and word register cycles
`timescale 1ns/1ns
module cfs_host_model (
	input  wire logic       clk_sys_i,
	output logic            reg_wr_o = 1'b0,
	output logic            reg_rd_o = 1'b0,
	output logic      [7:0] reg_addr_o = 8'h00,
	output logic      [7:0] reg_wdata_o = 8'h00,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= a;
		reg_wdata_o <= d;
	endtask
	// released data is inverted so a stale byte can never look valid
	task automatic done();
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_wdata_o <= ~reg_wdata_o;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(a, d);
		done();
	endtask
	// both bytes in one transaction, no gap between strobes
	task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
		put(a, d[7:0]);
		put(a + 8'h01, d[15:8]);
		done();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic ok);
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= a;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		#1;
		ok = reg_rvalid_i;
		q = reg_rdata_i;
	endtask
endmodule

/* File: tb_top.sv */
// testbench: register rows, programmed frequency, ratio source and recovery lock
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb_top;
	import cfs_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} cfs_row_t;
	logic       clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i, reg_rd_i, reg_rvalid_o, ok;
	logic       watchdog_timeout_i = 1'b0, watchdog_enable_i = 1'b0, strap_override_i = 1'b0;
	logic       use_nm_o, retune_o, sys_reset_o, recovery_locked_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, cpu_n_o, q;
	logic [6:0] cpu_m_o;
	logic [4:0] strap_freq_inputs_i = 5'h0A, sw_freq_select_i = 5'h00, ratio_select_o;
	int         err_total = 0, n_tests = 0;
	cfs_row_t   rows [6] = '{'{CFS_OFF_RECOV_N, 8'hC3, 8'hC3}, '{CFS_OFF_PROG_N, 8'hA5, 8'hA5},
		'{CFS_OFF_RSVD_ONES, 8'h03, 8'h03}, '{CFS_OFF_RSVD_SPARE, 8'hFF, 8'h00},
		'{8'h20, 8'h55, 8'h00}, '{CFS_OFF_RECOV_M, 8'h7F, 8'h7F}};
	always #25 clk_sys_i = ~clk_sys_i;
	cfs_top cfs_top_i (.*);
	cfs_host_model cfs_host_model_i (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
		.reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// time-out raised afresh; lock seen within a bounded wait
	task automatic trip();
		@(posedge clk_sys_i);
		watchdog_enable_i <= 1'b1;
		watchdog_timeout_i <= 1'b1;
		for (int k = 0; k < 10 && recovery_locked_o !== 1'b1; k++)
			@(posedge clk_sys_i) #1;
		`CHK("sys reset", 1'b1, sys_reset_o)
	endtask
	task automatic untrip();
		@(posedge clk_sys_i);
		watchdog_timeout_i <= 1'b0;
		watchdog_enable_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i) #1;
		`CHK("unlocked", 1'b0, recovery_locked_o)
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		for (int a = 11; a <= 16; a++) begin
			cfs_host_model_i.rd(8'(a), q, ok);
			`CHK("reset value", (a == 15) ? CFS_RST_RSVD_ONES : CFS_RST_BYTE, q)
		end
		$display("reset values done");
		foreach (rows[i]) begin
			cfs_host_model_i.wr(rows[i].a, rows[i].d);
			cfs_host_model_i.rd(rows[i].a, q, ok);
			`CHK("read valid", 1'b1, ok)
			`CHK("readback", rows[i].q, q)
		end
		$display("register rows done");
		cfs_host_model_i.wr(CFS_OFF_PROG_N, 8'h5A);
		`CHK("n alone retune", 1'b0, retune_o)
		cfs_host_model_i.wr(CFS_OFF_PROG_M, 8'h85);
		`CHK("m retune", 1'b1, retune_o)
		`CHK("nm mode", 1'b1, use_nm_o)
		`CHK("prog n", 8'h5A, cpu_n_o)
		`CHK("prog m", 7'h05, cpu_m_o)
		$display("programmed frequency done");
		@(posedge clk_sys_i);
		strap_override_i <= 1'b1;
		sw_freq_select_i <= 5'h13;
		repeat (6) @(posedge clk_sys_i) #1;
		`CHK("ratio select", 5'h13, ratio_select_o)
		@(posedge clk_sys_i);
		strap_override_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i) #1;
		`CHK("ratio strap", 5'h0A, ratio_select_o)
		$display("ratio source done");
		cfs_host_model_i.wr_word(CFS_OFF_RECOV_N, 16'h9230);
		`CHK("recovery word retune", 1'b1, retune_o)
		trip();
		`CHK("recovery nm", 1'b1, use_nm_o)
		`CHK("recovery n", 8'h30, cpu_n_o)
		`CHK("recovery m", 7'h12, cpu_m_o)
		cfs_host_model_i.wr(CFS_OFF_PROG_M, 8'h81);
		`CHK("locked retune", 1'b0, retune_o)
		cfs_host_model_i.rd(CFS_OFF_PROG_M, q, ok);
		`CHK("locked write dropped", 8'h85, q)
		untrip();
		cfs_host_model_i.wr(CFS_OFF_RECOV_M, 8'h12);
		trip();
		`CHK("strap recovery nm", 1'b0, use_nm_o)
		`CHK("strap recovery ratio", 5'h0A, ratio_select_o)
		untrip();
		$display("recovery lock done");
		cfs_host_model_i.wr(CFS_OFF_PROG_N, 8'hF8);
		cfs_host_model_i.wr(CFS_OFF_PROG_M, 8'hFF);
		`CHK("full n", 8'hF8, cpu_n_o)
		`CHK("full m", 7'h7F, cpu_m_o)
		cfs_host_model_i.wr(CFS_OFF_RECOV_N, 8'h44);
		`CHK("recovery n retune", 1'b1, retune_o)
		$display("full range and recovery retune done");
		complete_run();
	end
	initial begin
		#(2000 * 50);
		err_total++;
		complete_run();
	end
endmodule
